// *** hw/ebc_defs.svh ***
// offsets, field positions and reset values of the bus cycle controller
`ifndef EBC_DEFS_SVH
`define EBC_DEFS_SVH
`define EBC_OFS_CTRL 8'h00
`define EBC_OFS_ADDR 8'h04
`define EBC_OFS_WDATA 8'h08
`define EBC_OFS_STATUS 8'h0C
`define EBC_OFS_RDATA 8'h10
`define EBC_OFS_TIMING 8'h20
`define EBC_TIMING_STRIDE 8'h04
`define EBC_CTRL_START 0
`define EBC_CTRL_LO 1
`define EBC_CTRL_HI 9
`define EBC_STAT_BUSY 0
`define EBC_STAT_DONE 1
`define EBC_TIM_HI 12
`define EBC_TIMING_RESET 13'h0000
`define EBC_HALF_UNIT 2
`endif

// *** hw/ebc_pkg.sv ***
// types shared by the external bus cycle controller
package ebc_pkg;
  typedef enum logic [2:0] {
    ST_IDLE, ST_AB, ST_C, ST_D, ST_E, ST_WAIT, ST_F
  } phase_e;
  // one chip select's phase settings, values stored as printed fields
  typedef struct packed {
    logic [1:0] ab_ext; // extra address setup units on window change
    logic ab;           // address setup: 0 -> 1 unit, 1 -> 2 units
    logic [1:0] c;      // command delay units
    logic d;            // write data setup / turnaround units
    logic [4:0] e;      // access units minus one
    logic [1:0] f;      // hold units
  } timing_s;
  // cycle control word written by software
  typedef struct packed {
    logic wr_hi;        // write high byte
    logic wr_lo;        // write low byte
    logic rdy_async;    // ready passes the extra sync stage
    logic rdy_pol;      // ready active level
    logic rdy_en;       // ready handshake extends access
    logic [1:0] cs;     // chip select
    logic mux;          // multiplexed address/data
    logic rnw;          // 1 = read
  } ctl_s;
endpackage : ebc_pkg

// *** hw/external_bus_cycle_controller.sv ***
// five-phase external bus cycle controller with register port
//
// Our own choices: the address map and strobed register access.
`timescale 1ns/1ns
`default_nettype none
`include "ebc_defs.svh"
// Contract
// (R1) cycle runs AB, C, D, E, F in order
// (R2) phase lengths from per chip select registers
// (R3) setup 1-2 units, plus 0-3 on window change
// (R4) command delay 0-3, access 1-32 units
// (R5) data setup or turnaround 0-1 unit
// (R6) hold phase 0-3 units
// (R7) ready input may stretch the access phase
// (R8) read data captured when read strobe rises
// (R9) early address change leaves read data intact
// (R10) partner holds read data until strobe rises
// (R11) mux mode writes data on shared lines
// (R12) demux mode writes data on data bus
// (R13) 24-bit address on dedicated outputs
// (R14) read and byte write strobes during access
// (R15) drive byte high enable and address latch
// (R16) reference clock out times all bus signals
// (R17) software selects ready polarity
// (R18) async ready adds sync stage, one wait
// (R19) inactive ready waits, active ready ends
// (R20) partner drops ready before next sample
// (R21) one unit is one reference clock period
module external_bus_cycle_controller #(
  parameter int CHIP_SELECTS = 4,
  parameter int HALF_UNIT = `EBC_HALF_UNIT
) (
  input wire logic i_ref_clk,
  input wire logic i_nrst,
  input wire logic [7:0] i_reg_addr,
  input wire logic [31:0] i_reg_wdata,
  input wire logic i_reg_wr,
  input wire logic i_reg_rd,
  output logic [31:0] o_reg_rdata,
  input wire logic i_ready,
  input wire logic [15:0] i_muxed_addr_data_bus,
  input wire logic [15:0] i_demux_data_bus,
  output logic [23:0] o_addr_bus_out,
  output logic [15:0] o_muxed_addr_data_bus,
  output logic o_muxed_addr_data_bus_oe_n,
  output logic [15:0] o_demux_data_bus,
  output logic o_demux_data_bus_oe_n,
  output logic o_read_strobe_n,
  output logic o_write_low_n,
  output logic o_write_high_n,
  output logic o_byte_high_enable_n,
  output logic o_addr_latch_enable,
  output logic o_bus_ref_clock_out
);
  localparam int UNIT_CYC = 2 * HALF_UNIT;

  ebc_pkg::timing_s chip_select_timing_regs [CHIP_SELECTS];
  ebc_pkg::ctl_s ctl;
  ebc_pkg::timing_s cur;
  ebc_pkg::phase_e state, next_state;
  logic [23:0] addr;
  logic [15:0] wdata, rdata;
  logic [7:0] last_hi;
  logic pend, done, first_w, rdy_u;
  logic [4:0] cnt, next_cnt;
  logic [$clog2(HALF_UNIT+1)-1:0] div;
  logic rdy_s1, rdy_s2;
  logic [15:0] din_s1, din_s2;
  logic [15:0] dmx_s1, dmx_s2;
  ebc_pkg::timing_s sel;

  // phase length in units minus one; zero-length phases are skipped
  function automatic logic [4:0] phase_len(ebc_pkg::phase_e st,
                                           ebc_pkg::timing_s t,
                                           logic win);
    logic [4:0] n;
    n = 5'h00;
    unique case (st)
      ebc_pkg::ST_AB: n = {4'h0, t.ab} + (win ? {3'h0, t.ab_ext} : 5'h00); // R3
      ebc_pkg::ST_C: n = {3'h0, t.c} - 5'h01; // R4
      ebc_pkg::ST_D: n = 5'h00; // R5
      ebc_pkg::ST_E: n = t.e; // R4
      ebc_pkg::ST_F: n = {3'h0, t.f} - 5'h01; // R6
      ebc_pkg::ST_IDLE, ebc_pkg::ST_WAIT: n = 5'h00;
    endcase
    return n;
  endfunction

  // register decode
  wire wr_ctrl = i_reg_wr && i_reg_addr == `EBC_OFS_CTRL;
  wire wr_addr = i_reg_wr && i_reg_addr == `EBC_OFS_ADDR;
  wire wr_wdata = i_reg_wr && i_reg_addr == `EBC_OFS_WDATA;
  wire wr_stat = i_reg_wr && i_reg_addr == `EBC_OFS_STATUS;
  wire [7:0] tim_ofs = i_reg_addr - `EBC_OFS_TIMING;
  wire [7:0] tim_idx = tim_ofs / `EBC_TIMING_STRIDE;
  wire tim_hit = i_reg_addr >= `EBC_OFS_TIMING &&
                 tim_idx < 8'(CHIP_SELECTS) && tim_ofs[1:0] == 2'b00;
  wire busy = pend || state != ebc_pkg::ST_IDLE;
  wire start = wr_ctrl && i_reg_wdata[`EBC_CTRL_START] && !busy;
  wire [31:0] rd_mux =
    i_reg_addr == `EBC_OFS_CTRL ? {22'h0, ctl, 1'b0} :
    i_reg_addr == `EBC_OFS_ADDR ? {8'h00, addr} :
    i_reg_addr == `EBC_OFS_WDATA ? {16'h0000, wdata} :
    i_reg_addr == `EBC_OFS_STATUS ? {30'h0, done, busy} :
    i_reg_addr == `EBC_OFS_RDATA ? {16'h0000, rdata} :
    tim_hit ? {19'h0, chip_select_timing_regs[tim_idx[1:0]]} : 32'h0;

  // unit pulse marks each rising edge of the reference clock
  wire unit = div == ($bits(div))'(HALF_UNIT - 1) && !o_bus_ref_clock_out;
  wire unit_end = unit && cnt == 5'h00;
  wire win = addr[23:16] != last_hi;
  wire in_access = state == ebc_pkg::ST_E || state == ebc_pkg::ST_WAIT;
  wire rdy_level = ctl.rdy_async ? rdy_u : rdy_s2; // R18
  wire rdy_act = rdy_level == ctl.rdy_pol; // R17
  // bus choice made after both sync stages, never on a raw pin
  wire [15:0] din = ctl.mux ? din_s2 : dmx_s2;
  wire next_access = next_state == ebc_pkg::ST_E ||
                     next_state == ebc_pkg::ST_WAIT;
  wire next_busy = next_state != ebc_pkg::ST_IDLE;
  wire next_data = next_busy && next_state != ebc_pkg::ST_AB;
  wire leave_read = in_access && !next_access && ctl.rnw;
  ebc_pkg::phase_e after_e;
  assign after_e = cur.f != 2'b00 ? ebc_pkg::ST_F : ebc_pkg::ST_IDLE;
  // the first phase is sized before cur is loaded, so it reads the
  // selected chip select's set directly
  assign sel = chip_select_timing_regs[ctl.cs];

  // phase sequencing, one step per unit
  always_comb
  begin
    next_state = state;
    unique case (state)
      ebc_pkg::ST_IDLE: if (unit && pend) next_state = ebc_pkg::ST_AB; // R1
      ebc_pkg::ST_AB: if (unit_end) next_state = cur.c != 2'b00 ?
        ebc_pkg::ST_C : cur.d ? ebc_pkg::ST_D : ebc_pkg::ST_E; // R1
      ebc_pkg::ST_C: if (unit_end)
        next_state = cur.d ? ebc_pkg::ST_D : ebc_pkg::ST_E; // R1
      ebc_pkg::ST_D: if (unit_end) next_state = ebc_pkg::ST_E; // R1
      ebc_pkg::ST_E: if (unit_end)
        next_state = ctl.rdy_en ? ebc_pkg::ST_WAIT : after_e; // R7
      ebc_pkg::ST_WAIT: if (unit && !first_w && rdy_act)
        next_state = after_e; // R19
      ebc_pkg::ST_F: if (unit_end) next_state = ebc_pkg::ST_IDLE; // R1
    endcase
    next_cnt = cnt;
    if (next_state != state)
      next_cnt = phase_len(next_state,
        state == ebc_pkg::ST_IDLE ? sel : cur, win); // R21
    else if (unit && cnt != 5'h00)
      next_cnt = cnt - 5'h01;
  end

  // pin inputs pass two flops first
  always_ff @(posedge i_ref_clk or negedge i_nrst)
  begin
    if (!i_nrst) begin
      rdy_s1 <= 1'b0;
      rdy_s2 <= 1'b0;
      din_s1 <= 16'h0000;
      din_s2 <= 16'h0000;
      dmx_s1 <= 16'h0000;
      dmx_s2 <= 16'h0000;
    end else begin
      rdy_s1 <= i_ready;
      rdy_s2 <= rdy_s1;
      din_s1 <= i_muxed_addr_data_bus;
      din_s2 <= din_s1;
      dmx_s1 <= i_demux_data_bus;
      dmx_s2 <= dmx_s1;
    end
  end

  // reference clock divider
  always_ff @(posedge i_ref_clk or negedge i_nrst)
  begin
    if (!i_nrst) begin
      div <= '0;
      o_bus_ref_clock_out <= 1'b0;
    end else if (div == ($bits(div))'(HALF_UNIT - 1)) begin
      div <= '0;
      o_bus_ref_clock_out <= !o_bus_ref_clock_out; // R16
    end else begin
      div <= div + 1'b1;
    end
  end

  // software registers; a done set beats a clear in the same cycle
  always_ff @(posedge i_ref_clk or negedge i_nrst)
  begin
    if (!i_nrst) begin
      ctl <= '0;
      addr <= 24'h000000;
      wdata <= 16'h0000;
      pend <= 1'b0;
      done <= 1'b0;
      o_reg_rdata <= 32'h0;
      for (int i = 0; i < CHIP_SELECTS; i++)
        chip_select_timing_regs[i] <= `EBC_TIMING_RESET;
    end else begin
      o_reg_rdata <= i_reg_rd ? rd_mux : 32'h0;
      // control, address and write data are frozen while a cycle runs
      if (wr_ctrl && !busy)
        ctl <= i_reg_wdata[`EBC_CTRL_HI:`EBC_CTRL_LO];
      if (wr_addr && !busy) addr <= i_reg_wdata[23:0];
      if (wr_wdata && !busy) wdata <= i_reg_wdata[15:0];
      if (i_reg_wr && tim_hit) // R2
        chip_select_timing_regs[tim_idx[1:0]] <=
          i_reg_wdata[`EBC_TIM_HI:0];
      if (start) pend <= 1'b1;
      else if (state == ebc_pkg::ST_IDLE && unit) pend <= 1'b0;
      // a pending start alone is not a finished cycle
      if (state != ebc_pkg::ST_IDLE && !next_busy) done <= 1'b1;
      else if (start || (wr_stat && i_reg_wdata[`EBC_STAT_DONE]))
        done <= 1'b0;
    end
  end

  // phase machine and bus pins, pins follow the next phase
  always_ff @(posedge i_ref_clk or negedge i_nrst)
  begin
    if (!i_nrst) begin
      state <= ebc_pkg::ST_IDLE;
      cnt <= 5'h00;
      cur <= '0;
      last_hi <= 8'h00;
      first_w <= 1'b0;
      rdy_u <= 1'b0;
      rdata <= 16'h0000;
      o_addr_bus_out <= 24'h000000;
      o_muxed_addr_data_bus <= 16'h0000;
      o_muxed_addr_data_bus_oe_n <= 1'b1;
      o_demux_data_bus <= 16'h0000;
      o_demux_data_bus_oe_n <= 1'b1;
      o_read_strobe_n <= 1'b1;
      o_write_low_n <= 1'b1;
      o_write_high_n <= 1'b1;
      o_byte_high_enable_n <= 1'b1;
      o_addr_latch_enable <= 1'b0;
    end else begin
      state <= next_state;
      cnt <= next_cnt;
      if (state == ebc_pkg::ST_IDLE && next_busy) begin
        cur <= sel; // R2
        last_hi <= addr[23:16]; // R3
      end
      if (unit) rdy_u <= rdy_s2; // R18
      if (state == ebc_pkg::ST_E && next_state == ebc_pkg::ST_WAIT)
        first_w <= ctl.rdy_async; // R18
      else if (unit) first_w <= 1'b0;
      // partner keeps data valid up to this edge
      if (leave_read) rdata <= din; // R8 R10
      if (next_busy) o_addr_bus_out <= addr; // R13 R9
      o_addr_latch_enable <= next_state == ebc_pkg::ST_AB; // R15
      o_byte_high_enable_n <= !(next_busy && (ctl.rnw || ctl.wr_hi)); // R15
      o_muxed_addr_data_bus <= next_state == ebc_pkg::ST_AB ?
        addr[15:0] : wdata; // R11
      o_muxed_addr_data_bus_oe_n <= !(ctl.mux && (next_state ==
        ebc_pkg::ST_AB || (next_data && !ctl.rnw))); // R11 R5
      o_demux_data_bus <= wdata; // R12
      o_demux_data_bus_oe_n <= !(!ctl.mux && next_data && !ctl.rnw); // R12
      o_read_strobe_n <= !(next_access && ctl.rnw); // R14
      o_write_low_n <= !(next_access && !ctl.rnw && ctl.wr_lo); // R14
      o_write_high_n <= !(next_access && !ctl.rnw && ctl.wr_hi); // R14
    end
  end

  // one clock domain, so every check below shares clock and reset
  default clocking ebc_cb @(posedge i_ref_clk);
  endclocking
  default disable iff (!i_nrst);

  sequence s_unit_end;
    unit && cnt == 5'h00;
  endsequence
  sequence s_enter_access;
    state != ebc_pkg::ST_E ##1 state == ebc_pkg::ST_E;
  endsequence

  a_phase_order: assert property ( // R1
    state == ebc_pkg::ST_AB |=> state inside {ebc_pkg::ST_AB, ebc_pkg::ST_C,
      ebc_pkg::ST_D, ebc_pkg::ST_E}) else $error("phase left address setup");
  a_access_len: assert property ( // R4
    s_enter_access |-> cnt == cur.e) else $error("access length wrong");
  a_unit_period: assert property ( // R21
    unit |-> ##UNIT_CYC unit) else $error("unit period wrong");
  a_phase_end: assert property ( // R6
    state == ebc_pkg::ST_F ##0 s_unit_end |=> state == ebc_pkg::ST_IDLE)
    else $error("hold phase overran");
  a_strobe_access: assert property ( // R14
    !o_read_strobe_n |-> in_access && ctl.rnw) else $error("stray read");
  a_latch_setup: assert property ( // R15
    o_addr_latch_enable |-> state == ebc_pkg::ST_AB)
    else $error("stray latch");
  a_ready_wait: assert property ( // R19
    state == ebc_pkg::ST_WAIT && unit && !rdy_act
    |=> state == ebc_pkg::ST_WAIT) else $error("not-ready did not wait");
  // forced first wait spans a whole unit, at least four clocks
  a_ready_first: assert property ( // R18
    state == ebc_pkg::ST_E ##1 state == ebc_pkg::ST_WAIT && ctl.rdy_async
    |-> state == ebc_pkg::ST_WAIT [*4]) else $error("async no wait");
  a_read_capture: assert property ( // R8
    leave_read |=> rdata == $past(din) && o_read_strobe_n)
    else $error("read data not captured at strobe rise");
  a_mux_wdata: assert property ( // R11
    !o_write_low_n && ctl.mux |-> !o_muxed_addr_data_bus_oe_n &&
    o_muxed_addr_data_bus == wdata) else $error("mux write data missing");
  a_timing_load: assert property ( // R2
    state == ebc_pkg::ST_IDLE && next_busy |=> cur == $past(sel))
    else $error("timing set not loaded");
  a_done_end: assert property ( // R1
    state != ebc_pkg::ST_IDLE ##1 state == ebc_pkg::ST_IDLE |-> done)
    else $error("done not set at cycle end");
endmodule // external_bus_cycle_controller
`default_nettype wire

// *** verif/ext_bus_device.sv ***
// external bus device model: answers reads, stretches access, keeps writes
`timescale 1ns/1ns
`default_nettype none
module ext_bus_device (
  input wire logic i_clk,
  input wire logic i_read_strobe_n,
  input wire logic i_write_low_n,
  input wire logic i_write_high_n,
  input wire logic [15:0] i_mux_bus,
  input wire logic i_mux_oe_n,
  input wire logic [15:0] i_demux_bus,
  input wire logic [15:0] i_rdata,
  input wire logic [7:0] i_ready_delay,
  output logic [15:0] o_rdata,
  output logic o_ready,
  output logic [15:0] o_wdata
);
  logic [7:0] wait_cnt;
  logic cmd_low;
  assign cmd_low = !i_read_strobe_n || !i_write_low_n || !i_write_high_n;
  initial
  begin
    o_rdata = 16'h0000;
    o_ready = 1'b0;
    o_wdata = 16'h0000;
    wait_cnt = 8'h00;
  end
  // released data lines flip every cycle so stale values never match
  always @(posedge i_clk)
  begin
    if (!i_read_strobe_n)
      o_rdata <= i_rdata;
    else
      o_rdata <= ~o_rdata;
    if (!i_write_low_n || !i_write_high_n)
      o_wdata <= i_mux_oe_n ? i_demux_bus : i_mux_bus;
    wait_cnt <= cmd_low ? wait_cnt + 8'h01 : 8'h00;
    // ready dropped as soon as the command ends
    o_ready <= cmd_low && (wait_cnt >= i_ready_delay);
  end
endmodule // ext_bus_device
`default_nettype wire

// *** verif/tb_external_bus_cycle_controller.sv ***
// testbench: five bus cycles, mux and demux reads and writes, checked against programmed phases
`timescale 1ns/1ns
`default_nettype none
`include "ebc_defs.svh"
module tb_external_bus_cycle_controller;
  localparam int UNIT = 2 * `EBC_HALF_UNIT;
  typedef struct {
    ebc_pkg::timing_s t;
    logic [23:0] a;
    logic [15:0] wd;
    ebc_pkg::ctl_s c;
    logic [7:0] dly;
    logic ext;
  } case_s;
  logic clk, nrst, reg_wr, reg_rd, ready, ale, bhe_n, mux_oe_n, rs_n, wl_n;
  logic wh_n, dmx_oe_n, refclk, ref_q;
  logic [1:0] cap_oe;
  logic [7:0] reg_addr, rdy_dly;
  logic [31:0] reg_wdata, rdata, d;
  logic [15:0] dev_rdata, pin_data, mux_out, demux_out, dev_wdata;
  logic [23:0] addr_out, cap_addr;
  logic cap_bhe;
  int failures, compares, low_cnt, ale_cnt, cyc, ref_cnt;
  case_s tc [5];
  external_bus_cycle_controller dut_u (.i_ref_clk(clk), .i_nrst(nrst),
    .i_reg_addr(reg_addr), .i_reg_wdata(reg_wdata), .i_reg_wr(reg_wr),
    .i_reg_rd(reg_rd), .o_reg_rdata(rdata), .i_ready(ready),
    .i_muxed_addr_data_bus(pin_data), .i_demux_data_bus(pin_data),
    .o_addr_bus_out(addr_out), .o_muxed_addr_data_bus(mux_out),
    .o_muxed_addr_data_bus_oe_n(mux_oe_n), .o_demux_data_bus(demux_out),
    .o_demux_data_bus_oe_n(dmx_oe_n), .o_read_strobe_n(rs_n),
    .o_write_low_n(wl_n),
    .o_write_high_n(wh_n), .o_byte_high_enable_n(bhe_n),
    .o_addr_latch_enable(ale), .o_bus_ref_clock_out(refclk));
  ext_bus_device dev_u (.i_clk(clk), .i_read_strobe_n(rs_n),
    .i_write_low_n(wl_n), .i_write_high_n(wh_n), .i_mux_bus(mux_out),
    .i_mux_oe_n(mux_oe_n), .i_demux_bus(demux_out), .i_rdata(dev_rdata),
    .i_ready_delay(rdy_dly), .o_rdata(pin_data), .o_ready(ready),
    .o_wdata(dev_wdata));
  initial
  begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end
  // phase lengths seen on the pins, plus address, byte enable, drivers
  // and reference clock rises during access
  always @(posedge clk)
  begin
    cyc <= cyc + 1;
    ref_q <= refclk;
    if (ale === 1'b1) ale_cnt <= ale_cnt + 1;
    if (!(rs_n && wl_n && wh_n))
    begin
      low_cnt <= low_cnt + 1;
      cap_addr <= addr_out;
      cap_bhe <= bhe_n;
      cap_oe <= {mux_oe_n, dmx_oe_n};
      if (refclk && !ref_q) ref_cnt <= ref_cnt + 1;
    end
    if (cyc == 20000)
    begin
      failures++;
      results();
    end
  end
  task automatic wr(input logic [7:0] a, input logic [31:0] v);
    @(posedge clk);
    reg_addr <= a;
    reg_wdata <= v;
    reg_wr <= 1'b1;
    @(posedge clk);
    reg_wr <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, output logic [31:0] v);
    @(posedge clk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge clk);
    reg_rd <= 1'b0;
    #1 v = rdata;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp)
    begin
      failures++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic results();
    $display("compares %0d failures %0d", compares, failures);
    if (failures == 0 && compares > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask
  // one full cycle; an address write while busy is ignored
  task automatic run(input case_s k, input logic [15:0] src);
    logic [7:0] tofs;
    int n;
    tofs = `EBC_OFS_TIMING + {4'h0, k.c.cs, 2'b00};
    wr(tofs, {19'h00000, k.t});
    wr(`EBC_OFS_ADDR, {8'h00, k.a});
    wr(`EBC_OFS_WDATA, {16'h0000, k.wd});
    rdy_dly <= k.dly;
    dev_rdata <= src;
    low_cnt = 0;
    ale_cnt = 0;
    ref_cnt = 0;
    wr(`EBC_OFS_CTRL, {22'h000000, k.c, 1'b1});
    wr(`EBC_OFS_ADDR, {8'h00, ~k.a});
    d = 32'h0000_0000;
    for (n = 0; n < 200 && d[1] !== 1'b1; n++)
      rd(`EBC_OFS_STATUS, d);
    chk(d, 32'h0000_0002);
    wr(`EBC_OFS_STATUS, 32'h0000_0002);
  endtask
  initial
  begin
    failures = 0;
    compares = 0;
    cyc = 0;
    nrst = 1'b0;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    reg_addr = 8'h00;
    reg_wdata = 32'h0000_0000;
    rdy_dly = 8'h00;
    dev_rdata = 16'h0000;
    tc[0] = '{13'h0000, 24'h123456, 16'hA55A, 9'h184, 8'h00, 1'b0};
    tc[1] = '{13'h0797, 24'h12ABCD, 16'h3C96, 9'h08A, 8'h00, 1'b0};
    tc[2] = '{13'h187C, 24'h550010, 16'h0000, 9'h00D, 8'h00, 1'b1};
    tc[3] = '{13'h0100, 24'h550020, 16'h0000, 9'h033, 8'h28, 1'b0};
    tc[4] = '{13'h0000, 24'h550030, 16'h0000, 9'h071, 8'h00, 1'b0};
    repeat (4) @(posedge clk);
    nrst <= 1'b1;
    rd(`EBC_OFS_TIMING, d);
    chk(d, 32'h0000_0000);
    rd(8'h40, d);
    chk(d, 32'h0000_0000);
    wr(`EBC_OFS_TIMING + 8'h04, 32'hFFFF_FFFF);
    rd(`EBC_OFS_TIMING + 8'h04, d);
    chk(d, 32'h0000_1FFF);
    for (int i = 0; i < 5; i++)
    begin
      run(tc[i], 16'hC3A5 ^ 16'(i));
      chk(ale_cnt, (tc[i].t.ab + 1 + (tc[i].ext ? tc[i].t.ab_ext : 0))
        * UNIT);
      chk({8'h00, cap_addr}, {8'h00, tc[i].a});
      chk(cap_bhe, tc[i].c.rnw ? 1'b0 : !tc[i].c.wr_hi);
      chk(cap_oe, tc[i].c.rnw ? 2'b11 :
        tc[i].c.mux ? 2'b01 : 2'b10);
      chk(ref_cnt * UNIT, low_cnt);
      if (!tc[i].c.rdy_en)
        chk(low_cnt, (tc[i].t.e + 1) * UNIT);
      else if (tc[i].c.rdy_async)
        chk(low_cnt >= (tc[i].t.e + 2) * UNIT, 1'b1);
      else
        chk(low_cnt >= 40, 1'b1);
      if (tc[i].c.rnw)
      begin
        rd(`EBC_OFS_RDATA, d);
        chk(d, {16'h0000, 16'hC3A5 ^ 16'(i)});
      end
      else
        chk(dev_wdata, tc[i].wd);
    end
    results();
  end
endmodule // tb_external_bus_cycle_controller
`default_nettype wire
